// file: wsbs_checksum.sv
`timescale 1ns/1ps
// modular longword accumulator; carries fall off the top
module wsbs_checksum
    import wsbs_pkg::*;
(
    input  wire logic               core_clk,
    input  wire logic               rst,
    input  wire logic               clear,
    input  wire logic               add,
    input  wire logic [WSBS_DW-1:0] word,
    output logic [WSBS_DW-1:0]      sum
);
    logic [WSBS_DW-1:0] next_sum;

    always_comb
    begin
        next_sum = sum;
        if (clear)
            next_sum = '0;
        else if (add)
            next_sum = sum + word; // R16
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
            sum <= '0;
        else
            sum <= next_sum;
    end
endmodule

// file: wsbs_mem_model.sv
`timescale 1ns/1ps
// idle read data toggles every cycle so a stale value is never mistaken for an answer
module wsbs_mem_model
    import wsbs_pkg::*;
(
    input  wire logic               core_clk,
    input  wire logic               slow,
    input  wire logic               mem_req,
    input  wire logic               mem_we,
    input  wire logic [WSBS_AW-1:0] mem_addr,
    input  wire logic [WSBS_DW-1:0] mem_wdata,
    output logic                    mem_ack,
    output logic [WSBS_DW-1:0]      mem_rdata
);
    logic [WSBS_DW-1:0] mem [0:1023];
    logic [1:0]         wait_cnt;

    initial
    begin
        mem_ack   = 1'b0;
        mem_rdata = 32'h0000_0000;
        wait_cnt  = 2'h0;
    end

    always @(posedge core_clk)
    begin
        mem_ack   <= 1'b0;
        mem_rdata <= ~mem_rdata;
        if (mem_req && !mem_ack)
        begin
            if (wait_cnt >= (slow ? 2'h2 : 2'h0))
            begin
                mem_ack  <= 1'b1;
                wait_cnt <= 2'h0;
                if (mem_we)
                    mem[mem_addr[11:2]] <= mem_wdata;
                else
                    mem_rdata <= mem[mem_addr[11:2]];
            end
            else
                wait_cnt <= wait_cnt + 2'h1;
        end
    end
endmodule

// file: wsbs_mem_port.sv
`timescale 1ns/1ps
// single-outstanding memory read/write sequencer; one access at a time keeps ordering trivial
module wsbs_mem_port
    import wsbs_pkg::*;
(
    input  wire logic               core_clk,
    input  wire logic               rst,
    input  wire logic               req,
    input  wire logic               req_we,
    input  wire logic [WSBS_AW-1:0] req_addr,
    input  wire logic [WSBS_DW-1:0] req_wdata,
    output logic                    done,
    output logic [WSBS_DW-1:0]      rdata,
    output logic                    mem_req,
    output logic                    mem_we,
    output logic [WSBS_AW-1:0]      mem_addr,
    output logic [WSBS_DW-1:0]      mem_wdata,
    input  wire logic               mem_ack,
    input  wire logic [WSBS_DW-1:0] mem_rdata
);
    logic               next_mem_req;
    logic               next_mem_we;
    logic [WSBS_AW-1:0] next_mem_addr;
    logic [WSBS_DW-1:0] next_mem_wdata;
    logic               next_done;
    logic [WSBS_DW-1:0] next_rdata;

    always_comb
    begin
        next_mem_req   = mem_req;
        next_mem_we    = mem_we;
        next_mem_addr  = mem_addr;
        next_mem_wdata = mem_wdata;
        next_done      = 1'b0;
        next_rdata     = rdata;
        if (mem_req)
        begin
            if (mem_ack)
            begin
                next_mem_req = 1'b0;
                next_done    = 1'b1;
                next_rdata   = mem_rdata;
            end
        end
        else if (req && !done)
        begin
            next_mem_req   = 1'b1;
            next_mem_we    = req_we;
            next_mem_addr  = req_addr;
            next_mem_wdata = req_wdata;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            mem_req   <= 1'b0;
            mem_we    <= 1'b0;
            mem_addr  <= '0;
            mem_wdata <= '0;
            done      <= 1'b0;
            rdata     <= '0;
        end
        else
        begin
            mem_req   <= next_mem_req;
            mem_we    <= next_mem_we;
            mem_addr  <= next_mem_addr;
            mem_wdata <= next_mem_wdata;
            done      <= next_done;
            rdata     <= next_rdata;
        end
    end
endmodule

// file: wsbs_monitor.sv
`timescale 1ns/1ps
module wsbs_monitor
    import wsbs_pkg::*;
#(
    parameter logic [WSBS_AW-1:0] MEM_TOP = 32'h0010_0000
)
(
    input wire logic               core_clk,
    input wire logic               rst,
    input wire logic               power_event,
    input wire logic               halt_event,
    input wire logic [WSBS_DW-1:0] halt_code,
    input wire logic [1:0]         action_sel,
    input wire logic               mem_req,
    input wire logic               mem_we,
    input wire logic [WSBS_AW-1:0] mem_addr,
    input wire logic [WSBS_DW-1:0] mem_wdata,
    input wire logic               mem_ack,
    input wire logic               scan_done,
    input wire logic               scan_found,
    input wire logic               cpu_start,
    input wire logic [WSBS_DW-1:0] stack_pointer,
    input wire logic [WSBS_DW-1:0] argument_pointer,
    input wire logic [WSBS_AW-1:0] start_pc,
    input wire logic               cpu_halt,
    input wire logic               cpu_boot,
    input wire logic               busy
);
    logic        by_power;
    logic [1:0]  sel_cap;
    logic [31:0] code_cap;
    logic [31:0] flag_addr;
    logic        first_req;

    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    // capture the cause as the design takes it, so pointer checks need no bench help
    always_ff @(posedge core_clk)
    begin
        if (!busy && (power_event || halt_event))
        begin
            by_power <= power_event;
            sel_cap  <= action_sel;
            code_cap <= halt_code;
        end
        if (mem_req && mem_we && mem_ack)
            flag_addr <= mem_addr;
        first_req <= !busy || (first_req && !mem_req);
    end

    first_addr_a: assert property (
        mem_req && first_req |-> mem_addr == 32'h0000_0000) else $error("scan does not start at zero");
    scan_sel_a: assert property (
        mem_req |-> sel_cap[1]) else $error("memory access outside restart positions");
    flag_write_a: assert property (
        mem_req && mem_we |-> mem_addr[8:0] == 9'h00C && mem_wdata[WSBS_FLAG_BIT])
        else $error("bad flag write");
    write_start_a: assert property (
        mem_req && mem_we && mem_ack |-> ##[1:3] cpu_start) else $error("no start after flag write");
    start_sp_a: assert property (
        cpu_start |-> stack_pointer == flag_addr - 32'h0000_000C + WSBS_SP_OFFSET)
        else $error("stack pointer wrong");
    start_ap_a: assert property (
        cpu_start |-> argument_pointer == (by_power ? WSBS_AP_POWER : code_cap))
        else $error("argument pointer wrong");
    start_pc_a: assert property (
        cpu_start |-> start_pc != 32'h0000_0000) else $error("start at zero routine");
    miss_fallback_a: assert property (
        scan_done && !scan_found |=> (cpu_halt || cpu_boot) && !cpu_start) else $error("no fallback");
    fallback_sel_a: assert property (
        cpu_halt || cpu_boot |-> cpu_boot == sel_cap[0] && cpu_halt != sel_cap[0])
        else $error("fallback disagrees with selector");
    found_act_a: assert property (
        scan_done && scan_found |-> ##[1:20] (cpu_start || cpu_halt || cpu_boot))
        else $error("no action after found");

    cover property (cpu_start && !by_power);
    cover property (scan_done && !scan_found);
    cover property (cpu_boot && scan_found);
endmodule

bind wsbs_scanner wsbs_monitor #(.MEM_TOP(MEM_TOP)) i_wsbs_monitor (
    .core_clk(core_clk), .rst(rst), .power_event(power_event), .halt_event(halt_event),
    .halt_code(halt_code), .action_sel(action_sel), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .scan_done(scan_done),
    .scan_found(scan_found), .cpu_start(cpu_start), .stack_pointer(stack_pointer),
    .argument_pointer(argument_pointer), .start_pc(start_pc), .cpu_halt(cpu_halt),
    .cpu_boot(cpu_boot), .busy(busy));

// file: wsbs_pkg.sv
// Notes on behaviour
// (R1) block is four longwords, page aligned
// (R2) first longword equals block's own address
// (R3) restart routine pointer must be nonzero
// (R4) sum 31 longwords at routine, match third
// (R5) search upward from zero through memory
// (R6) scan only in restart positions of selector
// (R7) nothing found: halt or boot per selector
// (R8) flag set: skip restart, halt or boot
// (R9) flag clear: write flag to one first
// (R10) stack pointer gets block address plus 200h
// (R11) power or reset switch cause: argument 3
// (R12) halt cause: argument from halt code
// (R13) start processor at restart routine address
// (R14) read selector on gaining control, decide
// (R15) step one 512-byte page, stop at top
// (R16) modular checksum, scan-done before action
package wsbs_pkg;
    localparam int          WSBS_AW         = 32;
    localparam int          WSBS_DW         = 32;
    localparam logic [31:0] WSBS_PAGE_BYTES = 32'h0000_0200;
    localparam logic [31:0] WSBS_LW_BYTES   = 32'h0000_0004;
    localparam logic [31:0] WSBS_SP_OFFSET  = 32'h0000_0200;
    localparam logic [31:0] WSBS_AP_POWER   = 32'h0000_0003;
    localparam logic [4:0]  WSBS_SUM_LAST   = 5'h1E;
    localparam logic [1:0]  WSBS_OFF_SELF   = 2'h0;
    localparam logic [1:0]  WSBS_OFF_RTN    = 2'h1;
    localparam logic [1:0]  WSBS_OFF_SUM    = 2'h2;
    localparam logic [1:0]  WSBS_OFF_FLAG   = 2'h3;
    localparam int          WSBS_FLAG_BIT   = 0;

    typedef enum logic [1:0] {
        WSBS_SEL_HALT,
        WSBS_SEL_BOOT,
        WSBS_SEL_RESTART_HALT,
        WSBS_SEL_RESTART_BOOT
    } wsbs_sel_t;

    typedef enum logic [1:0] {
        WSBS_ACT_NONE,
        WSBS_ACT_RESTART,
        WSBS_ACT_HALT,
        WSBS_ACT_BOOT
    } wsbs_act_t;
endpackage

// file: wsbs_scanner.sv
`timescale 1ns/1ps
module wsbs_scanner
    import wsbs_pkg::*;
#(
    parameter logic [WSBS_AW-1:0] MEM_TOP = 32'h0010_0000
)
(
    input  wire logic               core_clk,
    input  wire logic               rst,
    input  wire logic               power_event,
    input  wire logic               halt_event,
    input  wire logic [WSBS_DW-1:0] halt_code,
    input  wire logic [1:0]         action_sel,
    input  wire logic [WSBS_AW-1:0] mem_size,
    output logic                    mem_req,
    output logic                    mem_we,
    output logic [WSBS_AW-1:0]      mem_addr,
    output logic [WSBS_DW-1:0]      mem_wdata,
    input  wire logic               mem_ack,
    input  wire logic [WSBS_DW-1:0] mem_rdata,
    output logic                    scan_done,
    output logic                    scan_found,
    output logic                    cpu_start,
    output logic [WSBS_DW-1:0]      stack_pointer,
    output logic [WSBS_DW-1:0]      argument_pointer,
    output logic [WSBS_AW-1:0]      start_pc,
    output logic                    cpu_halt,
    output logic                    cpu_boot,
    output logic                    busy
);
    typedef enum logic [3:0] {
        WSBS_IDLE,
        WSBS_RD_SELF,
        WSBS_RD_RTN,
        WSBS_RD_SUM,
        WSBS_RD_BODY,
        WSBS_RD_FLAG,
        WSBS_WR_FLAG,
        WSBS_DONE,
        WSBS_REPORT,
        WSBS_ACT
    } wsbs_state_t;

    wsbs_state_t        state;
    wsbs_state_t        next_state;
    logic [WSBS_AW-1:0] base;
    logic [WSBS_AW-1:0] next_base;
    logic [WSBS_AW-1:0] rtn;
    logic [WSBS_AW-1:0] next_rtn;
    logic [WSBS_DW-1:0] want_sum;
    logic [WSBS_DW-1:0] next_want_sum;
    logic [WSBS_DW-1:0] flag_word;
    logic [WSBS_DW-1:0] next_flag_word;
    logic [4:0]         idx;
    logic [4:0]         next_idx;
    logic [WSBS_DW-1:0] cause_ap;
    logic [WSBS_DW-1:0] next_cause_ap;
    logic [1:0]         sel;
    logic [1:0]         next_sel;
    wsbs_act_t          act;
    wsbs_act_t          next_act;
    logic               found;
    logic               next_found;
    logic               next_scan_done;
    logic [WSBS_DW-1:0] next_stack_pointer;
    logic [WSBS_DW-1:0] next_argument_pointer;
    logic [WSBS_AW-1:0] next_start_pc;

    logic               port_req;
    logic               port_we;
    logic [WSBS_AW-1:0] port_addr;
    logic [WSBS_DW-1:0] port_wdata;
    logic               port_done;
    logic [WSBS_DW-1:0] port_rdata;
    logic               sum_clear;
    logic               sum_add;
    logic [WSBS_DW-1:0] sum;
    logic [WSBS_AW-1:0] top;

    function automatic logic [WSBS_AW-1:0] lw_addr(input logic [WSBS_AW-1:0] b, input logic [1:0] off);
        lw_addr = b + WSBS_LW_BYTES * {30'h0, off}; // R1
    endfunction

    function automatic wsbs_act_t fallback(input logic [1:0] s);
        fallback = (s == WSBS_SEL_RESTART_BOOT || s == WSBS_SEL_BOOT) ? WSBS_ACT_BOOT : WSBS_ACT_HALT;
    endfunction

    // memory top from populated size, clipped to the build limit
    assign top = (mem_size != '0 && mem_size < MEM_TOP) ? mem_size : MEM_TOP; // R15

    wsbs_mem_port u_port (
        .core_clk  (core_clk),
        .rst       (rst),
        .req       (port_req),
        .req_we    (port_we),
        .req_addr  (port_addr),
        .req_wdata (port_wdata),
        .done      (port_done),
        .rdata     (port_rdata),
        .mem_req   (mem_req),
        .mem_we    (mem_we),
        .mem_addr  (mem_addr),
        .mem_wdata (mem_wdata),
        .mem_ack   (mem_ack),
        .mem_rdata (mem_rdata)
    );

    wsbs_checksum u_sum (
        .core_clk (core_clk),
        .rst      (rst),
        .clear    (sum_clear),
        .add      (sum_add),
        .word     (port_rdata),
        .sum      (sum)
    );

    always_comb
    begin
        port_req   = 1'b0;
        port_we    = 1'b0;
        port_addr  = lw_addr(base, WSBS_OFF_SELF);
        port_wdata = '0;
        unique case (state)
            WSBS_RD_SELF: port_req = 1'b1;
            WSBS_RD_RTN:
            begin
                port_req  = 1'b1;
                port_addr = lw_addr(base, WSBS_OFF_RTN);
            end
            WSBS_RD_SUM:
            begin
                port_req  = 1'b1;
                port_addr = lw_addr(base, WSBS_OFF_SUM);
            end
            WSBS_RD_BODY:
            begin
                port_req  = 1'b1;
                port_addr = rtn + WSBS_LW_BYTES * {27'h0, idx}; // R4
            end
            WSBS_RD_FLAG:
            begin
                port_req  = 1'b1;
                port_addr = lw_addr(base, WSBS_OFF_FLAG);
            end
            WSBS_WR_FLAG:
            begin
                port_req   = 1'b1;
                port_we    = 1'b1;
                port_addr  = lw_addr(base, WSBS_OFF_FLAG);
                port_wdata = flag_word | (32'h0000_0001 << WSBS_FLAG_BIT); // R9
            end
            default: ;
        endcase
    end

    assign sum_clear = (state == WSBS_RD_SUM);
    assign sum_add   = (state == WSBS_RD_BODY) && port_done;

    always_comb
    begin
        next_state            = state;
        next_base             = base;
        next_rtn              = rtn;
        next_want_sum         = want_sum;
        next_flag_word        = flag_word;
        next_idx              = idx;
        next_cause_ap         = cause_ap;
        next_sel              = sel;
        next_act              = act;
        next_found            = found;
        next_scan_done        = 1'b0;
        next_stack_pointer    = stack_pointer;
        next_argument_pointer = argument_pointer;
        next_start_pc         = start_pc;
        unique case (state)
            WSBS_IDLE:
            begin
                if (power_event || halt_event)
                begin
                    next_sel      = action_sel; // R14
                    next_cause_ap = power_event ? WSBS_AP_POWER : halt_code; // R11 R12
                    next_base     = '0; // R5
                    next_found    = 1'b0;
                    if (action_sel == WSBS_SEL_RESTART_HALT || action_sel == WSBS_SEL_RESTART_BOOT) // R6
                        next_state = WSBS_RD_SELF;
                    else
                    begin
                        next_act   = fallback(action_sel); // R14
                        next_state = WSBS_ACT;
                    end
                end
            end
            WSBS_RD_SELF:
                if (port_done)
                    next_state = (port_rdata == base) ? WSBS_RD_RTN : WSBS_DONE; // R2
            WSBS_RD_RTN:
                if (port_done)
                begin
                    next_rtn   = port_rdata;
                    next_state = (port_rdata != '0) ? WSBS_RD_SUM : WSBS_DONE; // R3
                end
            WSBS_RD_SUM:
                if (port_done)
                begin
                    next_want_sum = port_rdata;
                    next_idx      = '0;
                    next_state    = WSBS_RD_BODY;
                end
            WSBS_RD_BODY:
                if (port_done)
                begin
                    next_idx = idx + 5'h01;
                    if (idx == WSBS_SUM_LAST)
                        next_state = WSBS_RD_FLAG;
                end
            WSBS_RD_FLAG:
            begin
                // sum register now holds all 31 words
                if (port_done)
                begin
                    next_flag_word = port_rdata;
                    next_state     = WSBS_DONE;
                    next_found     = (sum == want_sum); // R4
                end
            end
            WSBS_DONE:
            begin
                if (found)
                begin
                    next_scan_done = 1'b1; // R16
                    if (flag_word[WSBS_FLAG_BIT])
                    begin
                        next_act   = fallback(sel); // R8
                        next_state = WSBS_REPORT;
                    end
                    else
                        next_state = WSBS_WR_FLAG; // R9
                end
                else if (base + WSBS_PAGE_BYTES >= top || base + WSBS_PAGE_BYTES < base)
                begin
                    next_scan_done = 1'b1; // R16
                    next_act       = fallback(sel); // R7
                    next_state     = WSBS_REPORT;
                end
                else
                begin
                    next_base  = base + WSBS_PAGE_BYTES; // R15
                    next_state = WSBS_RD_SELF;
                end
            end
            WSBS_WR_FLAG:
                if (port_done)
                begin
                    next_stack_pointer    = base + WSBS_SP_OFFSET; // R10
                    next_argument_pointer = cause_ap; // R11 R12
                    next_start_pc         = rtn; // R13
                    next_act              = WSBS_ACT_RESTART;
                    next_state            = WSBS_ACT;
                end
            // one cycle of scan_done alone, so the result is seen before any fallback fires
            WSBS_REPORT:
                next_state = WSBS_ACT; // R16
            WSBS_ACT:
            begin
                next_act   = WSBS_ACT_NONE;
                next_state = WSBS_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            state            <= WSBS_IDLE;
            base             <= '0;
            rtn              <= '0;
            want_sum         <= '0;
            flag_word        <= '0;
            idx              <= '0;
            cause_ap         <= '0;
            sel              <= '0;
            act              <= WSBS_ACT_NONE;
            found            <= 1'b0;
            scan_done        <= 1'b0;
            stack_pointer    <= '0;
            argument_pointer <= '0;
            start_pc         <= '0;
        end
        else
        begin
            state            <= next_state;
            base             <= next_base;
            rtn              <= next_rtn;
            want_sum         <= next_want_sum;
            flag_word        <= next_flag_word;
            idx              <= next_idx;
            cause_ap         <= next_cause_ap;
            sel              <= next_sel;
            act              <= next_act;
            found            <= next_found;
            scan_done        <= next_scan_done;
            stack_pointer    <= next_stack_pointer;
            argument_pointer <= next_argument_pointer;
            start_pc         <= next_start_pc;
        end
    end

    // actions fire in the ACT state, a cycle after scan_done for a scanned halt or boot, later for a restart
    assign scan_found = found;
    assign cpu_start  = (state == WSBS_ACT) && (act == WSBS_ACT_RESTART); // R13
    assign cpu_halt   = (state == WSBS_ACT) && (act == WSBS_ACT_HALT); // R7
    assign cpu_boot   = (state == WSBS_ACT) && (act == WSBS_ACT_BOOT); // R7
    assign busy       = (state != WSBS_IDLE);
endmodule

// file: wsbs_scanner_bench.sv
`timescale 1ns/1ps
module wsbs_scanner_bench;
    import wsbs_pkg::*;
    logic core_clk, rst, power_event, halt_event, slow, mem_req, mem_we, mem_ack;
    logic scan_done, scan_found, cpu_start, cpu_halt, cpu_boot, busy, got_found, got_done, got_busy;
    logic [1:0]  action_sel, outcome;
    logic [31:0] halt_code, mem_size, mem_addr, mem_wdata, mem_rdata, stack_pointer;
    logic [31:0] argument_pointer, start_pc, got_sp, got_ap, got_pc, blk_sum;
    int          failures, num_checks, cycles, req_cnt;

    wsbs_scanner #(.MEM_TOP(32'h0000_1000)) i_wsbs_scanner (.core_clk(core_clk), .rst(rst),
        .power_event(power_event), .halt_event(halt_event), .halt_code(halt_code),
        .action_sel(action_sel), .mem_size(mem_size), .mem_req(mem_req), .mem_we(mem_we),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
        .scan_done(scan_done), .scan_found(scan_found), .cpu_start(cpu_start),
        .stack_pointer(stack_pointer), .argument_pointer(argument_pointer), .start_pc(start_pc),
        .cpu_halt(cpu_halt), .cpu_boot(cpu_boot), .busy(busy));
    wsbs_mem_model i_wsbs_mem_model (.core_clk(core_clk), .slow(slow), .mem_req(mem_req),
        .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata));

    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic end_of_test;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            failures++;
            end_of_test();
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // good block at 0x400, routine at 0x800; the checksum wraps many times
    task automatic build(input logic [31:0] top);
        blk_sum = 32'h0000_0000;
        for (int i = 0; i < 1024; i++) i_wsbs_mem_model.mem[i] = 32'h0000_0000;
        for (int i = 0; i < 31; i++)
        begin
            i_wsbs_mem_model.mem[512 + i] = 32'h9E37_79B9 * (i + 1);
            blk_sum += 32'h9E37_79B9 * (i + 1);
        end
        i_wsbs_mem_model.mem[256] = 32'h0000_0400;
        i_wsbs_mem_model.mem[257] = 32'h0000_0800;
        i_wsbs_mem_model.mem[258] = blk_sum;
        mem_size <= top;
    endtask

    task automatic fire(input logic pwr, input logic [1:0] sel, input logic [31:0] code);
        outcome   = WSBS_ACT_NONE;
        got_found = 1'b0;
        got_done  = 1'b0;
        got_busy  = 1'b0;
        req_cnt   = 0;
        @(posedge core_clk);
        power_event <= pwr;
        halt_event  <= !pwr;
        action_sel  <= sel;
        halt_code   <= code;
        @(posedge core_clk);
        power_event <= 1'b0;
        halt_event  <= 1'b0;
        for (int n = 0; n < 8000 && outcome == WSBS_ACT_NONE; n++)
        begin
            #1;
            if (n == 0) got_busy = busy;
            if (scan_done === 1'b1)
            begin
                got_done  = 1'b1;
                got_found = scan_found;
            end
            if (mem_req === 1'b1 && mem_ack === 1'b1) req_cnt++;
            if (cpu_start === 1'b1)
            begin
                outcome = WSBS_ACT_RESTART;
                got_sp  = stack_pointer;
                got_ap  = argument_pointer;
                got_pc  = start_pc;
            end
            else if (cpu_halt === 1'b1) outcome = WSBS_ACT_HALT;
            else if (cpu_boot === 1'b1) outcome = WSBS_ACT_BOOT;
            @(posedge core_clk);
        end
        repeat (2) @(posedge core_clk);
    endtask

    task automatic t_restart_power;
        build(32'h0000_1000);
        fire(1'b1, 2'h2, 32'h0000_0000);
        check("outcome", {30'h0, outcome}, {30'h0, WSBS_ACT_RESTART});
        check("found", {31'h0, got_found}, 32'h0000_0001);
        check("busy", {31'h0, got_busy}, 32'h0000_0001);
        check("stack_pointer", got_sp, 32'h0000_0600);
        check("argument_pointer", got_ap, 32'h0000_0003);
        check("start_pc", got_pc, 32'h0000_0800);
        check("flag word", i_wsbs_mem_model.mem[259], 32'h0000_0001);
    endtask

    task automatic t_flag_set;
        fire(1'b0, 2'h3, 32'h0000_0055);
        check("flag set boot", {30'h0, outcome}, {30'h0, WSBS_ACT_BOOT});
        check("flag set found", {31'h0, got_found}, 32'h0000_0001);
        fire(1'b1, 2'h2, 32'h0000_0000);
        check("flag set halt", {30'h0, outcome}, {30'h0, WSBS_ACT_HALT});
    endtask

    task automatic t_halt_cause;
        i_wsbs_mem_model.mem[259] = 32'h0000_0000;
        slow <= 1'b1;
        fire(1'b0, 2'h2, 32'h0000_00A5);
        check("halt outcome", {30'h0, outcome}, {30'h0, WSBS_ACT_RESTART});
        check("halt argument", got_ap, 32'h0000_00A5);
        slow <= 1'b0;
    endtask

    // self mismatch, zero routine with zero sum, checksum off by one
    task automatic t_rejects;
        for (int k = 0; k < 3; k++)
        begin
            build(32'h0000_1000);
            if (k == 0) i_wsbs_mem_model.mem[256] = 32'h0000_0200;
            if (k == 1) i_wsbs_mem_model.mem[257] = 32'h0000_0000;
            if (k == 1) i_wsbs_mem_model.mem[258] = 32'h0000_0000;
            if (k == 2) i_wsbs_mem_model.mem[258] = blk_sum + 32'h0000_0001;
            fire(1'b1, 2'h3, 32'h0000_0000);
            check("reject outcome", {30'h0, outcome}, {30'h0, WSBS_ACT_BOOT});
            check("reject found", {30'h0, got_done, got_found}, 32'h0000_0002);
        end
    endtask

    task automatic t_top;
        build(32'h0000_0400);
        fire(1'b1, 2'h2, 32'h0000_0000);
        check("top outcome", {30'h0, outcome}, {30'h0, WSBS_ACT_HALT});
        check("top found", {30'h0, got_done, got_found}, 32'h0000_0002);
    endtask

    task automatic t_no_scan;
        for (int s = 0; s < 2; s++)
        begin
            build(32'h0000_1000);
            fire(1'b1, s[1:0], 32'h0000_0000);
            check("plain outcome", {30'h0, outcome}, s == 0 ? 32'h2 : 32'h3);
            check("plain accesses", req_cnt, 32'h0000_0000);
            check("plain busy", {31'h0, got_busy}, 32'h0000_0001);
        end
    endtask

    initial
    begin
        rst         = 1'b1;
        power_event = 1'b0;
        halt_event  = 1'b0;
        halt_code   = 32'h0000_0000;
        action_sel  = 2'h0;
        mem_size    = 32'h0000_1000;
        slow        = 1'b0;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        t_restart_power();
        t_flag_set();
        t_halt_cause();
        t_rejects();
        t_top();
        t_no_scan();
        end_of_test();
    end
endmodule
